// ---- design/lut_corr_pkg.sv ----
package lut_corr_pkg;

    // ************************************************************
    // Table geometry
    // ************************************************************
    localparam int LUT_DEPTH = 64; // Segments per input cycle
    localparam int LUT_IDX_W = 6; // Segment index width
    localparam int ENTRY_W = 8; // Signed byte entries
    localparam logic signed [7:0] ENTRY_RESET = 8'sh00; // Null table after reset
    localparam logic signed [7:0] ENTRY_MAX = 8'sh7F; // Largest legal magnitude

    // ************************************************************
    // Angle layout
    // ************************************************************
    localparam int ANGLE_W = 14; // Angle wraps modulo 16384
    localparam int SEG_IDX_LSB = 8; // Segment index sits in bits 13..8
    localparam int WEIGHT_W = 8; // Interpolation weight, bits 7..0
    localparam int LUT_SCALE_SHIFT = 2; // One entry step is four angle LSBs
    localparam int INTERP_SHIFT = WEIGHT_W - LUT_SCALE_SHIFT; // Drop weight, keep scale
    localparam int INTERP_W = 18; // Room for entry*256 plus slope*weight
    localparam logic [13:0] CORR_LIMIT = 14'h01FC; // 4 * 127

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int PIPE_LATENCY = 2; // Input sample to corrected output
    localparam int SPI_CLK_DIV_MIN = 4; // Serial clock ceiling while enabled

endpackage : lut_corr_pkg

// ---- design/lut_table_if.sv ----
`timescale 1ns/100ps

// Table load port and the two read ports used for interpolation
interface lut_table_if;
    logic wr_en; // One-cycle write strobe
    logic [5:0] wr_addr; // Entry being loaded
    logic signed [7:0] wr_data; // New entry value
    logic [5:0] idx_a; // Segment start entry
    logic [5:0] idx_b; // Segment end entry
    logic signed [7:0] data_a; // Value at idx_a
    logic signed [7:0] data_b; // Value at idx_b

    modport user (output wr_en, wr_addr, wr_data, idx_a, idx_b, input data_a, data_b);
    modport store (input wr_en, wr_addr, wr_data, idx_a, idx_b, output data_a, data_b);
endinterface : lut_table_if

// ---- design/lut_table.sv ----
`timescale 1ns/100ps

module lut_table
(
    input wire logic clk,
    input wire logic rst,
    lut_table_if.store tp
);

    // ************************************************************
    // Storage
    // ************************************************************
    logic signed [7:0] entry_r [lut_corr_pkg::LUT_DEPTH]; // Correction table

    // One process per entry; reset gives the null table
    for (genvar i = 0; i < lut_corr_pkg::LUT_DEPTH; i++)
    begin : g_entry
        always_ff @(posedge clk)
        begin
            if (rst)
                entry_r[i] <= lut_corr_pkg::ENTRY_RESET;
            else if (tp.wr_en && (tp.wr_addr == 6'(i))) // [R1]
                entry_r[i] <= tp.wr_data;
        end
    end

    // ************************************************************
    // Read ports
    // ************************************************************
    // Asynchronous reads keep the pipeline short; both ends of a segment
    always_comb
    begin
        tp.data_a = entry_r[tp.idx_a];
        tp.data_b = entry_r[tp.idx_b];
    end

endmodule : lut_table

// ---- design/angle_distortion_lut_correction.sv ----
`timescale 1ns/100ps

// How it works
// R1: 64 signed byte entries, loadable, correct angle
// R2: Correct only when enable bit is one
// R3: Master keeps serial clock at most core/4
// R4: 64 equal segments per input cycle
// R5: Interpolate between both segment end entries
// R6: Add interpolated correction to the angle
// R7: Entries +-127, each step four angle LSBs
// R8: Constant table gives constant phase offset
// R9: Index upper six bits, weight lower eight, wrap
module angle_distortion_lut_correction
(
    input wire logic clk,
    input wire logic rst,
    input wire logic lut_enable,
    input wire logic tbl_wr_en,
    input wire logic [5:0] tbl_wr_addr,
    input wire logic [7:0] tbl_wr_data,
    input wire logic angle_valid,
    input wire logic [13:0] angle_in,
    output logic angle_out_valid,
    output logic [13:0] angle_out
);

    // ************************************************************
    // Table store
    // ************************************************************
    lut_table_if tp (); // Carrier to the table module

    lut_table u_table
    (
        .clk (clk),
        .rst (rst),
        .tp (tp)
    );

    // Loading is passed through untouched; the serial side owns ordering
    assign tp.wr_en = tbl_wr_en; // [R1]
    assign tp.wr_addr = tbl_wr_addr;
    assign tp.wr_data = tbl_wr_data;

    // Segment start from the upper angle bits
    assign tp.idx_a = angle_in[13:lut_corr_pkg::SEG_IDX_LSB]; // [R4] [R9]
    // Six-bit add makes segment 63 end on entry 0
    assign tp.idx_b = tp.idx_a + 6'h01; // [R9]

    // ************************************************************
    // Stage 1: capture angle, weight and both ends
    // ************************************************************
    logic v1_r; // Stage 1 holds a sample
    logic en1_r; // Enable seen with the sample
    logic [13:0] ang1_r; // Raw angle
    logic [7:0] w1_r; // Position inside the segment
    logic signed [7:0] e0_r; // Entry at segment start
    logic signed [7:0] e1_r; // Entry at segment end

    // Valid flag and enable need a defined reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            v1_r <= 1'b0;
            en1_r <= 1'b0;
        end
        else
        begin
            v1_r <= angle_valid;
            en1_r <= lut_enable; // [R2]
        end
    end

    // Data path registers; only meaningful under v1_r
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ang1_r <= 14'h0000;
            w1_r <= 8'h00;
            e0_r <= 8'sh00;
            e1_r <= 8'sh00;
        end
        else if (angle_valid)
        begin
            ang1_r <= angle_in;
            w1_r <= angle_in[lut_corr_pkg::WEIGHT_W-1:0]; // [R9]
            e0_r <= tp.data_a; // [R5]
            e1_r <= tp.data_b; // [R5]
        end
    end

    // ************************************************************
    // Interpolation
    // ************************************************************
    logic signed [8:0] slope; // End minus start entry
    logic signed [17:0] prod; // Slope times weight at full width
    logic signed [17:0] interp; // Entry scaled by 256 plus slope*weight
    logic signed [17:0] corr_wide; // Correction in angle LSBs
    logic [13:0] corr; // Correction folded to angle width
    logic [13:0] ang_nxt; // Corrected or bypassed angle

    // Floor shift keeps the curve monotone between the two ends
    always_comb
    begin
        slope = 9'(e1_r) - 9'(e0_r);
        // Assigned at 18 bits so the product is not cut to nine bits
        prod = slope * $signed({1'b0, w1_r}); // [R5]
        interp = (18'(e0_r) <<< lut_corr_pkg::WEIGHT_W) + prod; // [R5]
        // Divide weight out and apply the four-LSB step in one shift
        corr_wide = interp >>> lut_corr_pkg::INTERP_SHIFT; // [R7]
        corr = corr_wide[13:0];
        // Two's complement add wraps modulo 16384
        if (en1_r)
            ang_nxt = ang1_r + corr; // [R6] [R8] [R9]
        else
            ang_nxt = ang1_r; // [R2]
    end

    // ************************************************************
    // Stage 2: output registers
    // ************************************************************
    // Valid follows the input with a fixed latency
    always_ff @(posedge clk)
    begin
        if (rst)
            angle_out_valid <= 1'b0;
        else
            angle_out_valid <= v1_r;
    end

    // Output angle holds between samples
    always_ff @(posedge clk)
    begin
        if (rst)
            angle_out <= 14'h0000;
        else if (v1_r)
            angle_out <= ang_nxt; // [R6]
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic [13:0] ang2_r; // Raw angle aligned with angle_out
    logic en2_r; // Enable aligned with angle_out
    logic [13:0] e0x4; // Start entry in angle LSBs
    logic [13:0] delta; // Applied correction at the output

    // Helper only read by the assertions
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ang2_r <= 14'h0000;
            en2_r <= 1'b0;
        end
        else if (v1_r)
        begin
            ang2_r <= ang1_r;
            en2_r <= en1_r;
        end
    end

    assign e0x4 = {{4{e0_r[7]}}, e0_r, 2'b00};
    assign delta = angle_out - ang2_r;

    // All checks run on the core clock and pause while in reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Table entries read through the hierarchy give an independent view of the index

    AST_TABLE_LOAD: assert property ( // [R1]
        (tbl_wr_en ##1 (angle_in[13:8] == $past(tbl_wr_addr)))
        |-> (tp.data_a == $signed($past(tbl_wr_data))))
        else $error("Loaded entry not read back");

    AST_BYPASS: assert property ( // [R2]
        (angle_valid && !lut_enable)
        |-> ##2 (angle_out_valid && angle_out == $past(angle_in, 2)))
        else $error("Bypass altered the angle");

    AST_SEGMENT_INDEX: assert property ( // [R4]
        angle_valid
        |=> (e0_r == $past(u_table.entry_r[angle_in[13:8]])
             && w1_r == $past(angle_in[7:0])))
        else $error("Wrong segment or weight captured");

    AST_SEG_START: assert property ( // [R5]
        (v1_r && en1_r && w1_r == 8'h00)
        |=> (angle_out == $past(ang1_r) + $past(e0x4)))
        else $error("Segment start not corrected by start entry");

    AST_LATENCY: assert property ( // [R6]
        angle_valid |-> ##2 angle_out_valid ##1 (angle_out_valid == $past(angle_valid, 2)))
        else $error("Output valid latency wrong");

    AST_RANGE: assert property ( // [R7]
        angle_out_valid && en2_r
        |-> (delta <= lut_corr_pkg::CORR_LIMIT || (-delta) <= lut_corr_pkg::CORR_LIMIT))
        else $error("Correction outside four times 127");

    AST_CONSTANT_OFFSET: assert property ( // [R8]
        (v1_r && en1_r && e0_r == e1_r)
        |=> (angle_out == $past(ang1_r) + $past(e0x4)))
        else $error("Constant table did not give constant offset");

    AST_LAST_SEG_WRAP: assert property ( // [R9]
        (angle_valid && angle_in[13:8] == 6'h3F) |=> (e1_r == $past(u_table.entry_r[0])))
        else $error("Last segment does not end on entry zero");

    AST_OUT_HOLD: assert property ( // [R6]
        !v1_r |=> $stable(angle_out))
        else $error("Output angle changed without a sample");

    // Main scenarios the bench is expected to reach

    COV_CORRECTED: cover property (angle_valid && lut_enable ##2 angle_out_valid);
    COV_BYPASS: cover property (angle_valid && !lut_enable ##2 angle_out_valid);
    COV_LAST_SEG: cover property (v1_r && en1_r && ang1_r[13:8] == 6'h3F && w1_r != 8'h00);
    COV_WRAP_DOWN: cover property (v1_r && en1_r && e0_r < 0 && ang1_r < 14'h0010);

endmodule : angle_distortion_lut_correction

// ---- testbench/angle_src.sv ----
`timescale 1ns/100ps

// ************************************************************
// Upstream angle datapath model
// ************************************************************
module angle_src
(
    input wire logic clk,
    output logic angle_valid,
    output logic [13:0] angle_in
);
    initial
    begin
        angle_valid = 1'b0;
        angle_in = 14'h0000;
    end

    // One sample per call, launched off the falling edge
    task put(input logic [13:0] a);
        @(negedge clk);
        angle_valid = 1'b1;
        angle_in = a;
    endtask : put

    // Stale word inverted so nothing leans on it
    task idle();
        @(negedge clk);
        angle_valid = 1'b0;
        angle_in = ~angle_in;
    endtask : idle
endmodule : angle_src

// ---- testbench/angle_distortion_lut_correction_tb.sv ----
`timescale 1ns/100ps

module angle_distortion_lut_correction_tb;
    logic clk, rst, lut_enable, tbl_wr_en, angle_valid, angle_out_valid;
    logic [5:0] tbl_wr_addr;
    logic [7:0] tbl_wr_data;
    logic [13:0] angle_in, angle_out;
    logic signed [7:0] tbl [64]; // Shadow of the table
    logic [13:0] expq [$]; // Results still due
    logic [1:0] vpipe; // Valid delayed to the answer edge
    int n_errors = 0;
    int n_checks = 0;
    int cycles = 0;

    angle_distortion_lut_correction DUT (.clk(clk), .rst(rst), .lut_enable(lut_enable),
        .tbl_wr_en(tbl_wr_en), .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data),
        .angle_valid(angle_valid), .angle_in(angle_in),
        .angle_out_valid(angle_out_valid), .angle_out(angle_out));
    angle_src SRC (.clk(clk), .angle_valid(angle_valid), .angle_in(angle_in));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // All int so the shift stays arithmetic (floor)
    function logic [13:0] expect_of(input logic [13:0] a, input logic en);
        int i, j, w, c;
        i = a[13:8];
        j = (i + 1) % 64;
        w = a[7:0];
        c = (int'(tbl[i]) * 256 + (int'(tbl[j]) - int'(tbl[i])) * w) >>> 6;
        return en ? a + c[13:0] : a;
    endfunction : expect_of

    task check(input string name, input logic [13:0] seen, input logic [13:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask : check

    task results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results

    // Settled sampling after each edge; latency fixed at two edges
    always @(posedge clk)
    begin
        vpipe <= rst ? 2'h0 : {vpipe[0], angle_valid};
        #2;
        if (!rst)
        begin
            check("out_valid", 14'(angle_out_valid), 14'(vpipe[1]));
            if (angle_out_valid === 1'b1 && expq.size() > 0)
                check("angle_out", angle_out, expq.pop_front());
        end
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            results();
        end
    end

    // Serial loading paces bytes; at most one per core/4 serial clocks
    task wr(input int ad, input logic [7:0] d);
        @(negedge clk);
        tbl_wr_en = 1'b1;
        tbl_wr_addr = 6'(ad);
        tbl_wr_data = d;
        tbl[ad] = d;
        @(negedge clk);
        tbl_wr_en = 1'b0;
        repeat (lut_corr_pkg::SPI_CLK_DIV_MIN - 2) @(negedge clk);
    endtask : wr

    // Sample launch also ends any write burst
    task send(input logic [13:0] a, input logic en);
        SRC.put(a);
        tbl_wr_en = 1'b0;
        lut_enable = en;
        expq.push_back(expect_of(a, en));
    endtask : send

    task drain();
        SRC.idle();
        repeat (4) @(negedge clk);
        check("pending", 14'(expq.size()), 14'h0000);
    endtask : drain

    task t_bypass();
        for (int k = 0; k < 64; k++)
            wr(k, 8'(k * 3 - 90));
        send(14'h1234, 1'b0);
        send(14'h3FFF, 1'b0);
        send(14'h1234, 1'b1);
        drain();
    endtask : t_bypass

    task t_const();
        for (int k = 0; k < 64; k++)
            wr(k, 8'hD5);
        check("const_model", expect_of(14'h0010, 1'b1), 14'h3F64);
        send(14'h0000, 1'b1);
        send(14'h0010, 1'b1);
        send(14'h2A55, 1'b1);
        send(14'h3FFF, 1'b1);
        drain();
    endtask : t_const

    task t_interp();
        wr(5, 8'h10);
        wr(6, 8'hE0);
        check("interp_model", expect_of(14'h0580, 1'b1), 14'h0560);
        send(14'h0500, 1'b1);
        send(14'h0540, 1'b0);
        send(14'h0580, 1'b1);
        send(14'h05FF, 1'b1);
        drain();
    endtask : t_interp

    task t_last();
        wr(63, 8'h7F);
        wr(0, 8'h81);
        check("last_model", expect_of(14'h3F00, 1'b1), 14'h00FC);
        send(14'h3F00, 1'b1);
        send(14'h3FC0, 1'b1);
        send(14'h0000, 1'b1);
        drain();
    endtask : t_last

    // Reset in mid-run must leave a null table behind
    task t_rst2();
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        foreach (tbl[k])
            tbl[k] = 8'h00;
        check("reset_out", angle_out, 14'h0000);
        send(14'h2222, 1'b1);
        drain();
    endtask : t_rst2

    initial
    begin
        rst = 1'b1;
        lut_enable = 1'b0;
        tbl_wr_en = 1'b0;
        tbl_wr_addr = 6'h00;
        tbl_wr_data = 8'h00;
        foreach (tbl[k])
            tbl[k] = 8'h00;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        check("reset_out", angle_out, 14'h0000);
        t_bypass();
        t_const();
        t_interp();
        t_last();
        t_rst2();
        results();
    end
endmodule : angle_distortion_lut_correction_tb
